// File: src/lpg_pkg.sv
// shared constants and carriers for the lcd/analog shared ports
package lpg_pkg;
    // register byte offsets (low address byte only)
    localparam logic [7:0] OFF_PA_LATCH = 8'h00;
    localparam logic [7:0] OFF_PA_DIR   = 8'h04;
    localparam logic [7:0] OFF_PB_PINS  = 8'h08;
    localparam logic [7:0] OFF_PB_FSEL  = 8'h0C;
    localparam logic [7:0] OFF_CFG      = 8'h10;

    // field positions
    localparam int FSEL_IRQ_BIT  = 3;
    localparam int CFG_SEG_LSB   = 0;
    localparam int CFG_CH_LSB    = 4;
    localparam int CFG_UREF_BIT  = 8;
    localparam int CFG_LREF_BIT  = 9;
    localparam int CFG_RISE_BIT  = 10;

    // reset values and fixed read patterns
    localparam logic [3:0] RSV_ONES     = 4'hF;
    localparam logic [3:0] PB_RSV_READ  = 4'h0;
    localparam logic [3:0] DIR_READ     = 4'hF;
    localparam logic [2:0] FSEL_LO_ONES = 3'h7;
    localparam logic [3:0] LATCH_RST    = 4'h0;
    localparam logic [3:0] DIR_RST      = 4'h0;
    localparam logic       IRQ_SEL_RST  = 1'b0;

    // segment code that leaves port a as general i/o
    localparam logic [3:0] SEG_GIO = 4'h0;
    // channel codes that route port b pins 0..3 to the converter
    localparam logic [3:0] AN_CODE [0:3] = '{4'h4, 4'h5, 4'h6, 4'h7};

    typedef struct packed {
        logic       edge_rise;
        logic       lower_ref_external_select;
        logic       upper_ref_external_select;
        logic [3:0] adc_channel_select;
        logic [3:0] lcd_segment_select;
    } lpg_cfg_t;

    localparam lpg_cfg_t CFG_RST = '0;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
    } lpg_req_t;
endpackage

// File: src/lpg_edge.sv
// edge detector for the shared external interrupt pin
`timescale 1ns/10ps
module lpg_edge (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic din,
    input  wire logic en,
    input  wire logic rise_sel,
    output logic      pulse_q
);
    logic prev_q;
    logic prev_d;
    logic pulse_d;

    always_comb begin
        prev_d  = din;
        // one edge polarity at a time, chosen by software
        if (rise_sel) begin
            pulse_d = en & din & ~prev_q;
        end else begin
            pulse_d = en & ~din & prev_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            prev_q  <= 1'b0;
            pulse_q <= 1'b0;
        end else begin
            prev_q  <= prev_d;
            pulse_q <= pulse_d;
        end
    end
endmodule

// File: src/lpg_top.sv
// lcd-shared port a and analog-shared port b with ahb-lite registers
//
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/10ps
module lpg_top #(
    parameter int PA_W = 4,
    parameter int PB_W = 4
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [3:0]  pa_in,
    output logic      [3:0]  pa_out,
    output logic      [3:0]  pa_oe_n,
    input  wire logic [3:0]  lcd_com,
    input  wire logic [3:0]  pb_in,
    output logic      [3:0]  an_sel,
    output logic             upper_ref_en,
    output logic             lower_ref_en,
    output logic             ext_int_pulse
);
    // bus request tracking
    lpg_pkg::lpg_req_t req_d;
    lpg_pkg::lpg_req_t req_q;
    logic              acc;

    // software-visible state
    logic [3:0]        port_a_output_latch_q;
    logic [3:0]        port_a_output_latch_d;
    logic [3:0]        port_a_direction_control_q;
    logic [3:0]        port_a_direction_control_d;
    logic              irq_sel_q;
    logic              irq_sel_d;
    lpg_pkg::lpg_cfg_t cfg_q;
    lpg_pkg::lpg_cfg_t cfg_d;

    // pin-side state
    logic [3:0]        pa_out_q;
    logic [3:0]        pa_out_d;
    logic [3:0]        pa_oe_n_q;
    logic [3:0]        pa_oe_n_d;
    logic [3:0]        an_sel_q;
    logic [3:0]        an_sel_d;
    logic              uref_q;
    logic              uref_d;
    logic              lref_q;
    logic              lref_d;
    logic [31:0]       hrdata_q;
    logic [31:0]       hrdata_d;
    logic              hreadyout_q;
    logic              hresp_q;
    logic              ext_int_q;
    logic              gio;
    logic [3:0]        route_sel;
    logic [3:0]        pa_read;
    logic [3:0]        pb_read;

    // word transfers only; the size field is accepted and not checked
    assign acc = hsel & hready & htrans[1];

    // ---------------- register writes ----------------
    always_comb begin
        req_d.wr   = acc & hwrite;
        req_d.rd   = acc & ~hwrite;
        req_d.addr = haddr[7:0];
        port_a_output_latch_d      = port_a_output_latch_q;
        port_a_direction_control_d = port_a_direction_control_q;
        irq_sel_d = irq_sel_q;
        cfg_d     = cfg_q;
        if (req_q.wr) begin
            if (req_q.addr == lpg_pkg::OFF_PA_LATCH) begin
                // latch updates in every pin mode
                port_a_output_latch_d = hwdata[3:0];
            end else if (req_q.addr == lpg_pkg::OFF_PA_DIR) begin
                port_a_direction_control_d = hwdata[3:0];
            end else if (req_q.addr == lpg_pkg::OFF_PB_FSEL) begin
                // only bit 3 is writable
                irq_sel_d = hwdata[lpg_pkg::FSEL_IRQ_BIT];
            end else if (req_q.addr == lpg_pkg::OFF_CFG) begin
                cfg_d.lcd_segment_select =
                    hwdata[lpg_pkg::CFG_SEG_LSB +: 4];
                cfg_d.adc_channel_select =
                    hwdata[lpg_pkg::CFG_CH_LSB +: 4];
                cfg_d.upper_ref_external_select =
                    hwdata[lpg_pkg::CFG_UREF_BIT];
                cfg_d.lower_ref_external_select =
                    hwdata[lpg_pkg::CFG_LREF_BIT];
                cfg_d.edge_rise = hwdata[lpg_pkg::CFG_RISE_BIT];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            req_q <= '0;
            port_a_output_latch_q      <= lpg_pkg::LATCH_RST;
            port_a_direction_control_q <= lpg_pkg::DIR_RST;
            irq_sel_q <= lpg_pkg::IRQ_SEL_RST;
            cfg_q     <= lpg_pkg::CFG_RST;
        end else begin
            req_q <= req_d;
            port_a_output_latch_q      <= port_a_output_latch_d;
            port_a_direction_control_q <= port_a_direction_control_d;
            irq_sel_q <= irq_sel_d;
            cfg_q     <= cfg_d;
        end
    end

    // ---------------- pin functions ----------------
    // mode is taken from the next-state values so a read that follows
    // a write back to back sees the new setting
    assign gio = (cfg_d.lcd_segment_select == lpg_pkg::SEG_GIO);

    genvar i;
    generate
        for (i = 0; i < PA_W; i++) begin : g_pa
            always_comb begin
                if (gio) begin
                    // direction and data drive the pins only in general i/o mode
                    pa_out_d[i]  = port_a_output_latch_d[i];
                    pa_oe_n_d[i] = ~port_a_direction_control_d[i];
                end else begin
                    pa_out_d[i]  = lcd_com[i];
                    pa_oe_n_d[i] = 1'b0;
                end
                if (port_a_direction_control_d[i]) begin
                    pa_read[i] = port_a_output_latch_d[i];
                end else begin
                    pa_read[i] = pa_in[i];
                end
            end
        end
        for (i = 0; i < PB_W; i++) begin : g_pb
            always_comb begin
                route_sel[i] = (cfg_d.adc_channel_select ==
                                lpg_pkg::AN_CODE[i]);
                pb_read[i]   = pb_in[i] & ~an_sel_d[i];
            end
        end
    endgenerate

    always_comb begin
        uref_d      = cfg_d.upper_ref_external_select;
        lref_d      = cfg_d.lower_ref_external_select;
        an_sel_d[0] = route_sel[0] & ~lref_d;
        an_sel_d[1] = route_sel[1] & ~uref_d;
        an_sel_d[2] = route_sel[2];
        an_sel_d[3] = route_sel[3] & ~irq_sel_d;
    end

    // ---------------- read data ----------------
    always_comb begin
        hrdata_d = '0;
        if (req_d.rd) begin
            if (req_d.addr == lpg_pkg::OFF_PA_LATCH) begin
                hrdata_d[7:0] = {lpg_pkg::RSV_ONES, pa_read};
            end else if (req_d.addr == lpg_pkg::OFF_PA_DIR) begin
                // written value is never visible
                hrdata_d[7:0] = {lpg_pkg::RSV_ONES, lpg_pkg::DIR_READ};
            end else if (req_d.addr == lpg_pkg::OFF_PB_PINS) begin
                hrdata_d[7:0] = {lpg_pkg::PB_RSV_READ, pb_read};
            end else if (req_d.addr == lpg_pkg::OFF_PB_FSEL) begin
                hrdata_d[7:0] = {lpg_pkg::RSV_ONES, irq_sel_d,
                                 lpg_pkg::FSEL_LO_ONES};
            end else if (req_d.addr == lpg_pkg::OFF_CFG) begin
                hrdata_d[10:0] = cfg_d;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pa_out_q    <= '0;
            pa_oe_n_q   <= '1;
            an_sel_q    <= '0;
            uref_q      <= 1'b0;
            lref_q      <= 1'b0;
            hrdata_q    <= '0;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end else begin
            pa_out_q    <= pa_out_d;
            pa_oe_n_q   <= pa_oe_n_d;
            an_sel_q    <= an_sel_d;
            uref_q      <= uref_d;
            lref_q      <= lref_d;
            hrdata_q    <= hrdata_d;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end
    end

    // interrupt edges reported only while it owns the shared pin
    lpg_edge u_edge (
        .mclk     (mclk),
        .rst      (rst),
        .din      (pb_in[3]),
        .en       (irq_sel_q),
        .rise_sel (cfg_q.edge_rise),
        .pulse_q  (ext_int_q)
    );

    assign hrdata       = hrdata_q;
    assign hreadyout    = hreadyout_q;
    assign hresp        = hresp_q;
    assign pa_out       = pa_out_q;
    assign pa_oe_n      = pa_oe_n_q;
    assign an_sel       = an_sel_q;
    assign upper_ref_en = uref_q;
    assign lower_ref_en = lref_q;
    assign ext_int_pulse = ext_int_q;

    // ---------------- checks ----------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_pa_rd_out;
        (req_d.rd && req_d.addr == lpg_pkg::OFF_PA_LATCH)
        |=> ((hrdata_q[3:0] & $past(port_a_direction_control_d))
             == ($past(port_a_output_latch_d)
                 & $past(port_a_direction_control_d)));
    endproperty
    a_pa_rd_out: assert property (p_pa_rd_out)
        else $error("port a output bit read wrong");

    property p_pa_rd_in;
        (req_d.rd && req_d.addr == lpg_pkg::OFF_PA_LATCH)
        |=> ((hrdata_q[3:0] & ~$past(port_a_direction_control_d))
             == ($past(pa_in) & ~$past(port_a_direction_control_d)));
    endproperty
    a_pa_rd_in: assert property (p_pa_rd_in)
        else $error("port a input bit read wrong");

    property p_pa_rsv;
        (req_d.rd && req_d.addr == lpg_pkg::OFF_PA_LATCH)
        |=> hrdata_q[7:4] == 4'hF;
    endproperty
    a_pa_rsv: assert property (p_pa_rsv)
        else $error("port a reserved bits not ones");

    property p_dir_drive;
        $past(gio) |-> (pa_oe_n_q == ~$past(port_a_direction_control_d));
    endproperty
    a_dir_drive: assert property (p_dir_drive)
        else $error("port a enable does not follow direction");

    property p_dir_rd;
        (req_d.rd && req_d.addr == lpg_pkg::OFF_PA_DIR)
        |=> hrdata_q == 32'h000000FF;
    endproperty
    a_dir_rd: assert property (p_dir_rd)
        else $error("direction read not all ones");

    property p_lcd;
        !gio |=> (pa_oe_n_q == 4'h0 && pa_out_q == $past(lcd_com));
    endproperty
    a_lcd: assert property (p_lcd)
        else $error("lcd common not driven");

    property p_pb_rd;
        (req_d.rd && req_d.addr == lpg_pkg::OFF_PB_PINS)
        |=> hrdata_q[3:0] == ($past(pb_in) & ~$past(an_sel_d));
    endproperty
    a_pb_rd: assert property (p_pb_rd)
        else $error("port b read wrong");

    property p_fsel_rd;
        (req_d.rd && req_d.addr == lpg_pkg::OFF_PB_FSEL)
        |=> (hrdata_q[7:4] == 4'hF && hrdata_q[2:0] == 3'h7);
    endproperty
    a_fsel_rd: assert property (p_fsel_rd)
        else $error("function select reserved bits not ones");

    property p_an3;
        (cfg_d.adc_channel_select == 4'h7 && !irq_sel_d) |=> an_sel_q[3];
    endproperty
    a_an3: assert property (p_an3)
        else $error("analog three not routed");

    property p_uref;
        cfg_d.upper_ref_external_select |=> (uref_q && !an_sel_q[1]);
    endproperty
    a_uref: assert property (p_uref)
        else $error("upper reference not selected");

    property p_an2;
        (cfg_d.adc_channel_select == 4'h6) |=> an_sel_q[2];
    endproperty
    a_an2: assert property (p_an2)
        else $error("analog two not routed");

    property p_lref;
        cfg_d.lower_ref_external_select |=> (lref_q && !an_sel_q[0]);
    endproperty
    a_lref: assert property (p_lref)
        else $error("lower reference not selected");

    property p_irq_rise;
        (irq_sel_q && cfg_q.edge_rise && pb_in[3] && !$past(pb_in[3]))
        |=> ext_int_q;
    endproperty
    a_irq_rise: assert property (p_irq_rise)
        else $error("rising edge missed");

    property p_irq_fall;
        (irq_sel_q && !cfg_q.edge_rise && !pb_in[3] && $past(pb_in[3]))
        |=> ext_int_q;
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("falling edge missed");

    property p_irq_off;
        !irq_sel_q |=> !ext_int_q;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("interrupt pulse while pin not selected");

    property p_latch_wr;
        (req_q.wr && req_q.addr == lpg_pkg::OFF_PA_LATCH)
        |=> port_a_output_latch_q == $past(hwdata[3:0]);
    endproperty
    a_latch_wr: assert property (p_latch_wr)
        else $error("latch write lost");

    c_pa_out: cover property (gio && port_a_direction_control_q != 4'h0);
    c_lcd: cover property (!gio ##1 gio);
    c_an_rd: cover property (req_d.rd && req_d.addr == lpg_pkg::OFF_PB_PINS
                             && an_sel_d != 4'h0);
    c_irq: cover property (ext_int_q);
endmodule

// File: verification/lpg_board.sv
// board-side model of the port pins and the circuitry behind them
`timescale 1ns/10ps
module lpg_board (
    input  wire logic [3:0] pa_out,
    input  wire logic [3:0] pa_oe_n,
    input  wire logic [3:0] pa_ext,
    input  wire logic [3:0] pb_ext,
    output logic      [3:0] pa_in,
    output logic      [3:0] pb_in
);
    // a released pin shows the board level, never the last drive
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pa_in[i] = pa_oe_n[i] ? pa_ext[i] : pa_out[i];
        end
    end
    // port b pins are inputs only, set by the board alone
    assign pb_in = pb_ext;
endmodule

// File: verification/lcd_and_analog_shared_ports_bench.sv
// self-checking bench for the lcd and analog shared ports
`timescale 1ns/10ps
module lcd_and_analog_shared_ports_bench;
    typedef struct packed {
        logic [3:0]  dir;
        logic [3:0]  lat;
        logic [3:0]  pae;
        logic [11:0] cfg;
        logic [3:0]  pbe;
        logic [3:0]  rd_a;
        logic [3:0]  oe_n;
        logic [3:0]  drv;
        logic [3:0]  an;
        logic [1:0]  refs;
        logic [3:0]  rd_b;
    } lpg_row_t;

    logic        mclk;
    logic        rst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [3:0]  pa_in;
    logic [3:0]  pa_out;
    logic [3:0]  pa_oe_n;
    logic [3:0]  lcd_com;
    logic [3:0]  pb_in;
    logic [3:0]  an_sel;
    logic        upper_ref_en;
    logic        lower_ref_en;
    logic        ext_int_pulse;
    logic [3:0]  pa_ext;
    logic [3:0]  pb_ext;
    int          miscompares;
    int          compares;

    // dir, latch, pin, cfg, pb pins -> pa read, oe_n, drive, analog, refs, pb read
    lpg_row_t rows [0:7] = '{
        '{4'hF, 4'h5, 4'hA, 12'h000, 4'hF, 4'h5, 4'h0, 4'h5, 4'h0, 2'h0, 4'hF},
        '{4'h0, 4'h5, 4'hA, 12'h040, 4'hF, 4'hA, 4'hF, 4'h0, 4'h1, 2'h0, 4'hE},
        '{4'h3, 4'hC, 4'h6, 12'h050, 4'hF, 4'h4, 4'hC, 4'h0, 4'h2, 2'h0, 4'hD},
        '{4'hF, 4'h3, 4'h0, 12'h161, 4'hF, 4'h3, 4'h0, 4'hA, 4'h4, 2'h2, 4'hB},
        '{4'h0, 4'h9, 4'h5, 12'h27F, 4'hF, 4'hA, 4'h0, 4'hA, 4'h8, 2'h1, 4'h7},
        '{4'hA, 4'hF, 4'h0, 12'h380, 4'h5, 4'hA, 4'h5, 4'hA, 4'h0, 2'h3, 4'h5},
        '{4'h0, 4'h0, 4'h3, 12'h240, 4'hA, 4'h3, 4'hF, 4'h0, 4'h0, 2'h1, 4'hA},
        '{4'hF, 4'hE, 4'h0, 12'h150, 4'hF, 4'hE, 4'h0, 4'hE, 4'h0, 2'h2, 4'hF}
    };

    assign hready = hreadyout;

    lpg_top lpg_top_i (
        .mclk         (mclk),
        .rst          (rst),
        .hsel         (hsel),
        .haddr        (haddr),
        .htrans       (htrans),
        .hwrite       (hwrite),
        .hsize        (hsize),
        .hready       (hready),
        .hwdata       (hwdata),
        .hrdata       (hrdata),
        .hreadyout    (hreadyout),
        .hresp        (hresp),
        .pa_in        (pa_in),
        .pa_out       (pa_out),
        .pa_oe_n      (pa_oe_n),
        .lcd_com      (lcd_com),
        .pb_in        (pb_in),
        .an_sel       (an_sel),
        .upper_ref_en (upper_ref_en),
        .lower_ref_en (lower_ref_en),
        .ext_int_pulse (ext_int_pulse)
    );

    lpg_board lpg_board_i (
        .pa_out  (pa_out),
        .pa_oe_n (pa_oe_n),
        .pa_ext  (pa_ext),
        .pb_ext  (pb_ext),
        .pa_in   (pa_in),
        .pb_in   (pb_in)
    );

    always #5 mclk = ~mclk;

    task automatic test_done;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask

    // bounded wait for a rising edge with ready high
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge mclk);
        while (hreadyout !== 1'b1 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 20) begin
            miscompares++;
            $display("unexpected at %0t: bus never ready", $time);
            test_done;
        end
    endtask

    task automatic ahb_go(input logic [7:0] a, input logic wr, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        hsize <= 3'h2;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic ahb_wr(input logic [7:0] a, input logic [31:0] d);
        ahb_go(a, 1'b1, d);
    endtask

    // read data is taken at the edge closing the data phase
    task automatic ahb_rd(input logic [7:0] a, input logic [31:0] exp);
        ahb_go(a, 1'b0, 32'h0);
        chk(hrdata, exp);
    endtask

    task automatic pulses(input int cyc, input int exp);
        int n;
        n = 0;
        repeat (cyc) begin
            @(posedge mclk);
            if (ext_int_pulse === 1'b1) n++;
        end
        chk(n, exp);
    endtask

    task automatic rst_chk;
        chk({28'h0, pa_oe_n}, 32'hF);
        chk({28'h0, an_sel}, 32'h0);
        ahb_rd(lpg_pkg::OFF_PA_LATCH, {24'h0, 4'hF, pa_ext});
        ahb_rd(lpg_pkg::OFF_PA_DIR, 32'hFF);
        ahb_rd(lpg_pkg::OFF_PB_FSEL, 32'hF7);
        ahb_rd(lpg_pkg::OFF_CFG, 32'h0);
    endtask

    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        lcd_com = 4'hA;
        pa_ext = 4'h6;
        pb_ext = 4'hF;
        miscompares = 0;
        compares = 0;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rst_chk;
        for (int i = 0; i < 8; i++) begin
            // latch written before direction: it must hold while still an input
            ahb_wr(lpg_pkg::OFF_CFG, {20'h0, rows[i].cfg});
            ahb_wr(lpg_pkg::OFF_PA_LATCH, {24'h0, 4'hF, rows[i].lat});
            ahb_wr(lpg_pkg::OFF_PA_DIR, {24'h0, 4'hF, rows[i].dir});
            pa_ext <= rows[i].pae;
            pb_ext <= rows[i].pbe;
            repeat (2) @(posedge mclk);
            chk({28'h0, pa_oe_n}, {28'h0, rows[i].oe_n});
            chk({28'h0, pa_out & ~pa_oe_n}, {28'h0, rows[i].drv & ~rows[i].oe_n});
            chk({28'h0, an_sel}, {28'h0, rows[i].an});
            chk({30'h0, upper_ref_en, lower_ref_en}, {30'h0, rows[i].refs});
            ahb_rd(lpg_pkg::OFF_PA_LATCH, {24'h0, 4'hF, rows[i].rd_a});
            ahb_rd(lpg_pkg::OFF_PB_PINS, {28'h0, rows[i].rd_b});
        end
        ahb_wr(lpg_pkg::OFF_PA_DIR, 32'hF5);
        ahb_rd(lpg_pkg::OFF_PA_DIR, 32'hFF);
        // a changing common level shows a stale or held lcd path
        ahb_wr(lpg_pkg::OFF_CFG, 32'h001);
        lcd_com <= 4'h3;
        repeat (2) @(posedge mclk);
        chk({28'h0, pa_out}, 32'h3);
        chk({28'h0, pa_oe_n}, 32'h0);
        ahb_rd(lpg_pkg::OFF_PA_LATCH, 32'hF6);
        ahb_wr(lpg_pkg::OFF_PB_PINS, 32'h0);
        ahb_rd(lpg_pkg::OFF_PB_PINS, 32'hF);
        ahb_wr(8'h40, 32'hFFFF_FFFF);
        ahb_rd(8'h40, 32'h0);
        // pin 3 low before the interrupt is selected, so no stale edge
        pb_ext <= 4'h0;
        ahb_wr(lpg_pkg::OFF_CFG, 32'h470);
        ahb_wr(lpg_pkg::OFF_PB_FSEL, 32'hFF);
        ahb_rd(lpg_pkg::OFF_PB_FSEL, 32'hFF);
        repeat (2) @(posedge mclk);
        chk({28'h0, an_sel}, 32'h0);
        pb_ext[3] <= 1'b1;
        pulses(6, 1);
        pb_ext[3] <= 1'b0;
        pulses(6, 0);
        ahb_wr(lpg_pkg::OFF_CFG, 32'h070);
        pb_ext[3] <= 1'b1;
        pulses(6, 0);
        pb_ext[3] <= 1'b0;
        pulses(6, 1);
        ahb_wr(lpg_pkg::OFF_PB_FSEL, 32'h0);
        ahb_rd(lpg_pkg::OFF_PB_FSEL, 32'hF7);
        repeat (2) @(posedge mclk);
        chk({28'h0, an_sel}, 32'h8);
        pb_ext[3] <= 1'b1;
        pulses(6, 0);
        ahb_rd(lpg_pkg::OFF_PB_PINS, 32'h0);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rst_chk;
        test_done;
    end
endmodule
